// file: hdl/sacm_defs.svh
`ifndef SACM_DEFS_SVH
`define SACM_DEFS_SVH
// alarm codes
`define SACM_ALM_NONE     8'h00
`define SACM_ALM_D2       8'hD2
`define SACM_ALM_D3       8'hD3
`define SACM_ALM_DF       8'hDF
`define SACM_ALM_E1       8'hE1
`define SACM_ALM_E2       8'hE2
`define SACM_ALM_E3       8'hE3
`define SACM_ALM_E4       8'hE4
`define SACM_ALM_E5       8'hE5
`define SACM_ALM_E6       8'hE6
// sticky bit positions, lowest index = highest priority on the code output
`define SACM_B_E1         0
`define SACM_B_E2         1
`define SACM_B_E3         2
`define SACM_B_E4         3
`define SACM_B_E5         4
`define SACM_B_E6         5
`define SACM_B_D3         6
`define SACM_B_D2         7
`define SACM_B_DF         8
`define SACM_NALM         9
// timing
`define SACM_CLK_MHZ      10
`define SACM_CLK_NS       100
`define SACM_WIN_US       1000
`define SACM_WIN_CYC      (`SACM_WIN_US * `SACM_CLK_MHZ)
// least half period passed by each input filter setting, rounded up
`define SACM_FILT0_NS     200
`define SACM_FILT1_NS     400
`define SACM_FILT2_NS     800
`define SACM_FILT3_NS     1600
`define SACM_NS2CYC(ns)   (((ns) + `SACM_CLK_NS - 1) / `SACM_CLK_NS)
// permitted pulse counts per window
`define SACM_MAX_RATE     1000
`define SACM_MAX_SCALED   4000
// nonvolatile image sums to this value when intact
`define SACM_CSUM_OK      16'h0000
`endif

// file: hdl/sacm_pkg.sv
package sacm_pkg;
	typedef logic [7:0]  sacm_code_t;
	typedef logic [15:0] sacm_word_t;
	// power-on sequence, gray along the path
	typedef enum logic [2:0]
	{
		ST_NVM   = 3'b000,
		ST_RAM   = 3'b001,
		ST_LINK  = 3'b011,
		ST_PARAM = 3'b010,
		ST_RUN   = 3'b110
	} sacm_state_e;
endpackage : sacm_pkg

// file: hdl/sacm_pulse_if.sv
`timescale 1ns/1ps
interface sacm_pulse_if;
	logic        short_pls;
	logic        win_done;
	logic [15:0] rate_cnt;
	modport meter (output short_pls, output win_done, output rate_cnt);
	modport mon   (input short_pls, input win_done, input rate_cnt);
endinterface : sacm_pulse_if

// file: hdl/sacm_pulse_meter.sv
`timescale 1ns/1ps
`include "sacm_defs.svh"
module sacm_pulse_meter #(
	parameter int WIN_CYC = `SACM_WIN_CYC
)(
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       cmd_pulse,
	input  wire logic [7:0] filt_min,
	sacm_pulse_if.meter     pm
);
	import sacm_pkg::*;

	logic        sync1_ff;
	logic        sync2_ff;
	logic        prev_ff;
	logic [7:0]  gap_ff;
	logic [31:0] win_ff;
	logic [15:0] cnt_ff;
	logic        short_ff;
	logic        done_ff;
	logic [15:0] rate_ff;
	logic        rise;
	logic        edge_any;

	// ==========================================
	// pin synchroniser
	// two stages; only the second stage is looked at
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end
		else
		begin
			sync1_ff <= cmd_pulse;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	assign rise     = sync2_ff & ~prev_ff;
	assign edge_any = sync2_ff ^ prev_ff;

	// ==========================================
	// level width check against the filter
	// saturating, so long idle levels never wrap into a false short
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// start saturated: the idle line before reset counts as a long level
			gap_ff   <= 8'hFF;
			short_ff <= 1'b0;
		end
		else
		begin
			short_ff <= edge_any && (gap_ff < filt_min);
			if (edge_any)
				gap_ff <= 8'h01;
			else if (gap_ff != 8'hFF)
				gap_ff <= gap_ff + 8'h01;
		end
	end

	// ==========================================
	// rising edges counted over a fixed window
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			win_ff  <= 32'h0000_0000;
			cnt_ff  <= 16'h0000;
			done_ff <= 1'b0;
			rate_ff <= 16'h0000;
		end
		else
		begin
			done_ff <= 1'b0;
			if (win_ff == 32'(WIN_CYC - 1))
			begin
				win_ff  <= 32'h0000_0000;
				rate_ff <= cnt_ff + {15'h0000, rise && (cnt_ff != 16'hFFFF)};
				cnt_ff  <= 16'h0000;
				done_ff <= 1'b1;
			end
			else
			begin
				win_ff <= win_ff + 32'h0000_0001;
				if (rise && cnt_ff != 16'hFFFF)
					cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end

	assign pm.short_pls = short_ff;
	assign pm.win_done  = done_ff;
	assign pm.rate_cnt  = rate_ff;
endmodule : sacm_pulse_meter

// file: hdl/sacm_top.sv
// Contract
// - pulse levels shorter than the selected input filter pass raise code D2.
// - command pulse rate above the permitted maximum raises code D3.
// - rate scaled by the electronic gear above its limit raises D3.
// - end of a test-mode run raises code DF as a notice.
// - nonvolatile read returning a wrong value raises E1, at power-on or access.
// - power-on checksum mismatch of the nonvolatile image raises E2.
// - power-on internal RAM test failure raises E3.
// - power-on processor to control logic exchange failure raises E4.
// - system parameter out of range raises E5, at power-on and after changes.
// - parameters mismatching hardware or badly combined raise E6, same checks.
`timescale 1ns/1ps
`include "sacm_defs.svh"
module sacm_top #(
	parameter int WIN_CYC = `SACM_WIN_CYC
)(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              cmd_pulse,
	input  wire logic [1:0]        filt_sel,
	input  wire logic [15:0]       gear_num,
	input  wire logic [15:0]       gear_den,
	input  wire logic              test_run_end,
	input  wire logic              alarm_clr,
	input  wire logic              nvm_rd_valid,
	input  wire sacm_pkg::sacm_word_t nvm_rd_data,
	input  wire logic              nvm_rd_bad,
	input  wire logic              nvm_rd_last,
	input  wire logic              ram_test_done,
	input  wire logic              ram_test_pass,
	input  wire logic              link_test_done,
	input  wire logic              link_test_pass,
	input  wire logic              param_in_range,
	input  wire logic              param_hw_match,
	input  wire logic              param_changed,
	output logic                   nvm_rd_start,
	output logic                   ram_test_start,
	output logic                   link_test_start,
	output logic                   init_done,
	output logic                   alarm_active,
	output sacm_pkg::sacm_code_t   alarm_code
);
	import sacm_pkg::*;

	sacm_pulse_if pif ();

	sacm_state_e        state_ff;
	sacm_state_e        nxt_state;
	logic               nvm_go_ff;
	logic               ram_go_ff;
	logic               link_go_ff;
	logic               init_ff;
	logic               boot_ff;
	logic [15:0]        csum_ff;
	logic [`SACM_NALM-1:0] alm_ff;
	logic [`SACM_NALM-1:0] set_vec;
	logic               act_ff;
	sacm_code_t         code_ff;
	sacm_code_t         nxt_code;
	logic [7:0]         filt_min;
	logic [15:0]        csum_sum;
	logic [31:0]        scaled;
	logic [31:0]        scaled_lim;
	logic               param_chk;

	// ==========================================
	// filter setting to least level width in cycles
	always_comb
	begin
		unique case (filt_sel)
			2'd0: filt_min = 8'(`SACM_NS2CYC(`SACM_FILT0_NS));
			2'd1: filt_min = 8'(`SACM_NS2CYC(`SACM_FILT1_NS));
			2'd2: filt_min = 8'(`SACM_NS2CYC(`SACM_FILT2_NS));
			2'd3: filt_min = 8'(`SACM_NS2CYC(`SACM_FILT3_NS));
		endcase
	end

	sacm_pulse_meter #(
		.WIN_CYC   (WIN_CYC)
	) u_meter (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.cmd_pulse (cmd_pulse),
		.filt_min  (filt_min),
		.pm        (pif.meter)
	);

	// ==========================================
	// power-on check sequence
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_NVM:   if (nvm_rd_valid && nvm_rd_last) nxt_state = ST_RAM;
			ST_RAM:   if (ram_test_done) nxt_state = ST_LINK;
			ST_LINK:  if (link_test_done) nxt_state = ST_PARAM;
			ST_PARAM: nxt_state = ST_RUN;
			ST_RUN:   nxt_state = ST_RUN;
			default:  nxt_state = ST_NVM;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= ST_NVM;
		else
			state_ff <= nxt_state;
	end

	// ==========================================
	// one-cycle start strobes on entry to the nvm, ram and link steps; init_ff rises on entry to ST_RUN and holds
	// the nvm read is kicked on the first edge after reset release
	// boot_ff marks the kick as sent, so a slow memory never gets a second one
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			boot_ff    <= 1'b0;
			nvm_go_ff  <= 1'b0;
			ram_go_ff  <= 1'b0;
			link_go_ff <= 1'b0;
			init_ff    <= 1'b0;
		end
		else
		begin
			boot_ff    <= 1'b1;
			nvm_go_ff  <= (state_ff == ST_NVM) && !boot_ff;
			ram_go_ff  <= (state_ff == ST_NVM) && (nxt_state == ST_RAM);
			link_go_ff <= (state_ff == ST_RAM) && (nxt_state == ST_LINK);
			init_ff    <= (nxt_state == ST_RUN);
		end
	end

	// ==========================================
	// running checksum over the power-on image
	assign csum_sum = csum_ff + nvm_rd_data;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			csum_ff <= 16'h0000;
		else if (state_ff == ST_NVM && nvm_rd_valid)
			csum_ff <= csum_sum;
	end

	// ==========================================
	// fault detection
	// gear check done as a cross product to avoid a divider
	assign scaled     = 32'(pif.rate_cnt) * 32'(gear_num);
	assign scaled_lim = 32'(`SACM_MAX_SCALED) * 32'(gear_den);
	assign param_chk  = (state_ff == ST_PARAM) || (init_ff && param_changed);

	always_comb
	begin
		set_vec = '0;
		set_vec[`SACM_B_D2] = pif.short_pls;
		set_vec[`SACM_B_D3] = pif.win_done
			&& ((pif.rate_cnt > 16'(`SACM_MAX_RATE))
			|| (scaled > scaled_lim));
		set_vec[`SACM_B_DF] = test_run_end;
		// reads during keypad or setup access are checked too
		set_vec[`SACM_B_E1] = nvm_rd_valid && nvm_rd_bad;
		set_vec[`SACM_B_E2] = (state_ff == ST_NVM) && nvm_rd_valid && nvm_rd_last
			&& (csum_sum != `SACM_CSUM_OK);
		set_vec[`SACM_B_E3] = (state_ff == ST_RAM) && ram_test_done && !ram_test_pass;
		set_vec[`SACM_B_E4] = (state_ff == ST_LINK) && link_test_done
			&& !link_test_pass;
		set_vec[`SACM_B_E5] = param_chk && !param_in_range;
		set_vec[`SACM_B_E6] = param_chk && !param_hw_match;
	end

	// ==========================================
	// sticky alarms; a new event beats a clear in the same cycle
	// memory and parameter alarms ignore alarm_clr: only reset drops them
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			alm_ff <= '0;
		else
		begin
			if (alarm_clr)
			begin
				alm_ff[`SACM_B_D2] <= 1'b0;
				alm_ff[`SACM_B_D3] <= 1'b0;
				alm_ff[`SACM_B_DF] <= 1'b0;
			end
			for (int i = 0; i < `SACM_NALM; i++)
				if (set_vec[i])
					alm_ff[i] <= 1'b1;
		end
	end

	// ==========================================
	// code of the highest priority pending alarm
	always_comb
	begin
		nxt_code = `SACM_ALM_NONE;
		if (alm_ff[`SACM_B_E1])
			nxt_code = `SACM_ALM_E1;
		else if (alm_ff[`SACM_B_E2])
			nxt_code = `SACM_ALM_E2;
		else if (alm_ff[`SACM_B_E3])
			nxt_code = `SACM_ALM_E3;
		else if (alm_ff[`SACM_B_E4])
			nxt_code = `SACM_ALM_E4;
		else if (alm_ff[`SACM_B_E5])
			nxt_code = `SACM_ALM_E5;
		else if (alm_ff[`SACM_B_E6])
			nxt_code = `SACM_ALM_E6;
		else if (alm_ff[`SACM_B_D3])
			nxt_code = `SACM_ALM_D3;
		else if (alm_ff[`SACM_B_D2])
			nxt_code = `SACM_ALM_D2;
		else if (alm_ff[`SACM_B_DF])
			nxt_code = `SACM_ALM_DF;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			code_ff <= `SACM_ALM_NONE;
			act_ff  <= 1'b0;
		end
		else
		begin
			code_ff <= nxt_code;
			act_ff  <= |alm_ff;
		end
	end

	assign nvm_rd_start    = nvm_go_ff;
	assign ram_test_start  = ram_go_ff;
	assign link_test_start = link_go_ff;
	assign init_done       = init_ff;
	assign alarm_active    = act_ff;
	assign alarm_code      = code_ff;
endmodule : sacm_top

// file: tb/sacm_host_model.sv
`timescale 1ns/1ps
// =====================================
// host controller pulse source
module sacm_host_model (
	input  wire logic        pls_en,
	input  wire logic [15:0] pls_half,
	output logic             cmd_pulse
);
	// free-running train while enabled; line parks low between bursts
	initial cmd_pulse = 1'h0;
	always
	begin
		if (pls_en)
		begin
			#(pls_half) cmd_pulse = ~cmd_pulse;
		end
		else
		begin
			cmd_pulse = 1'h0;
			#10;
		end
	end
endmodule : sacm_host_model

// file: tb/sacm_top_props.sv
`timescale 1ns/1ps
`include "sacm_defs.svh"
// =====================================
// port-level checker
module sacm_top_props (
	input wire logic                 core_clk,
	input wire logic                 rstn,
	input wire logic                 test_run_end,
	input wire logic                 nvm_rd_valid,
	input wire logic                 nvm_rd_bad,
	input wire logic                 ram_test_done,
	input wire logic                 ram_test_pass,
	input wire logic                 link_test_done,
	input wire logic                 link_test_pass,
	input wire logic                 param_in_range,
	input wire logic                 param_hw_match,
	input wire logic                 param_changed,
	input wire logic                 nvm_rd_start,
	input wire logic                 ram_test_start,
	input wire logic                 link_test_start,
	input wire logic                 init_done,
	input wire logic                 alarm_active,
	input wire sacm_pkg::sacm_code_t alarm_code
);
	import sacm_pkg::*;
	logic ram_wait_ff;
	logic link_wait_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// which tester is awaited; done pulses elsewhere are ignored by design
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			ram_wait_ff <= 1'h0;
		else if (ram_test_start | ram_test_done)
			ram_wait_ff <= ram_test_start;
	end
	// same tracking for the link tester
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			link_wait_ff <= 1'h0;
		else if (link_test_start | link_test_done)
			link_wait_ff <= link_test_start;
	end
	chk_boot_strobe: assert property ($rose(rstn) |=> nvm_rd_start ##1 !nvm_rd_start)
		else $error("image read strobe wrong after reset");
	chk_df_notice: assert property (test_run_end |-> ##2 alarm_active)
		else $error("test close notice missing");
	chk_e1_code: assert property (nvm_rd_valid && nvm_rd_bad |-> ##2 alarm_code == `SACM_ALM_E1)
		else $error("bad read code missing");
	chk_ram_fail: assert property (ram_wait_ff && ram_test_done && !ram_test_pass |-> ##2 alarm_active)
		else $error("ram failure not flagged");
	chk_link_fail: assert property (link_wait_ff && link_test_done && !link_test_pass |-> ##2 alarm_active)
		else $error("link failure not flagged");
	chk_init_order: assert property (link_wait_ff && link_test_done |-> !init_done ##2 init_done)
		else $error("init done timing wrong");
	chk_param_chg: assert property (init_done && param_changed && !(param_in_range && param_hw_match)
		|-> ##2 alarm_active)
		else $error("parameter change fault not flagged");
	chk_e_sticky: assert property (alarm_code[7:4] == 4'hE |=> alarm_active && alarm_code[7:4] == 4'hE)
		else $error("memory or parameter alarm dropped");
endmodule : sacm_top_props

bind sacm_top sacm_top_props u_props (.core_clk, .rstn, .test_run_end, .nvm_rd_valid, .nvm_rd_bad,
	.ram_test_done, .ram_test_pass, .link_test_done, .link_test_pass, .param_in_range,
	.param_hw_match, .param_changed, .nvm_rd_start, .ram_test_start, .link_test_start,
	.init_done, .alarm_active, .alarm_code);

// file: tb/test_servo_alarm_code_monitor.sv
`timescale 1ns/1ps
`include "sacm_defs.svh"
module test_servo_alarm_code_monitor;
	import sacm_pkg::*;
	// =====================================
	// stimulus, all driven at the falling edge
	logic core_clk = 1'h0, rstn = 1'h0, cmd_pulse, pls_en = 1'h0;
	logic [15:0] pls_half = 16'h0190, gear_num = 16'h0001, gear_den = 16'h0001;
	logic [1:0] filt_sel = 2'h0;
	logic test_run_end = 1'h0, alarm_clr = 1'h0, nvm_rd_valid = 1'h0, nvm_rd_bad = 1'h0;
	logic nvm_rd_last = 1'h0, ram_test_done = 1'h0, ram_test_pass = 1'h0, link_test_done = 1'h0;
	logic link_test_pass = 1'h0, param_in_range = 1'h1, param_hw_match = 1'h1, param_changed = 1'h0;
	sacm_word_t nvm_rd_data = 16'h0000;
	logic nvm_rd_start, ram_test_start, link_test_start, init_done, alarm_active;
	sacm_code_t alarm_code;
	int fails = 0;
	int checked = 0;
	// window long enough that the plain rate limit can really be crossed
	localparam int WIN = 2100;
	always #50 core_clk = ~core_clk;
	sacm_top #(.WIN_CYC(WIN)) DUT (.core_clk, .rstn, .cmd_pulse, .filt_sel, .gear_num, .gear_den,
		.test_run_end, .alarm_clr, .nvm_rd_valid, .nvm_rd_data, .nvm_rd_bad, .nvm_rd_last,
		.ram_test_done, .ram_test_pass, .link_test_done, .link_test_pass, .param_in_range,
		.param_hw_match, .param_changed, .nvm_rd_start, .ram_test_start, .link_test_start,
		.init_done, .alarm_active, .alarm_code);
	sacm_host_model u_host (.pls_en, .pls_half, .cmd_pulse);

	// =====================================
	// shared helpers
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic strobe(ref logic s);
		s = 1'h1;
		tick(1);
		s = 1'h0;
	endtask : strobe
	task automatic check(input sacm_code_t seen, input sacm_code_t exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// f: bad read, bad sum, ram fail, link fail, out of range, hw mismatch
	task automatic power_on(input logic [5:0] f, input sacm_code_t exp);
		rstn = 1'h0;
		param_in_range = !f[4];
		param_hw_match = !f[5];
		tick(2);
		rstn = 1'h1;
		tick(2);
		nvm_rd_valid = 1'h1;
		nvm_rd_bad = f[0];
		nvm_rd_data = 16'h1234;
		tick(1);
		nvm_rd_bad = 1'h0;
		nvm_rd_last = 1'h1;
		nvm_rd_data = 16'hEDCC + 16'(f[1]); // wraps to zero when intact
		tick(1);
		nvm_rd_valid = 1'h0;
		nvm_rd_last = 1'h0;
		check({7'h00, ram_test_start}, 8'h01);
		tick(2);
		ram_test_pass = !f[2];
		strobe(ram_test_done);
		check({7'h00, link_test_start}, 8'h01);
		tick(2);
		link_test_pass = !f[3];
		strobe(link_test_done);
		tick(4);
		check(alarm_code, exp);
	endtask : power_on

	// =====================================
	// scenarios
	task automatic test_power_on;
		logic [5:0] flags [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F};
		sacm_code_t codes [8] = '{`SACM_ALM_NONE, `SACM_ALM_E1, `SACM_ALM_E2, `SACM_ALM_E3,
			`SACM_ALM_E4, `SACM_ALM_E5, `SACM_ALM_E6, `SACM_ALM_E1};
		for (int i = 0; i < 8; i++)
			power_on(flags[i], codes[i]);
		// clear request must not touch a memory alarm
		strobe(alarm_clr);
		tick(2);
		check(alarm_code, `SACM_ALM_E1);
		power_on(6'h00, `SACM_ALM_NONE);
		check({7'h00, init_done}, 8'h01);
		$display("power-on checks done");
	endtask : test_power_on
	task automatic run_pulses(input logic [1:0] fs, input logic [15:0] gn, input logic [15:0] hp,
		input sacm_code_t exp);
		filt_sel = fs;
		gear_num = gn;
		pls_half = hp;
		// two windows on so one lies wholly inside the train, one more to flush
		pls_en = 1'h1;
		tick(2 * WIN + 100);
		pls_en = 1'h0;
		tick(WIN + 100);
		check(alarm_code, exp);
		strobe(alarm_clr);
		tick(2);
		check(alarm_code, `SACM_ALM_NONE);
	endtask : run_pulses
	task automatic test_events;
		strobe(test_run_end);
		tick(2);
		check(alarm_code, `SACM_ALM_DF);
		strobe(alarm_clr);
		tick(2);
		check(alarm_code, `SACM_ALM_NONE);
		run_pulses(2'h0, 16'h0001, 16'h0190, `SACM_ALM_NONE);
		run_pulses(2'h3, 16'h0001, 16'h0190, `SACM_ALM_D2);
		run_pulses(2'h3, 16'h0200, 16'h0190, `SACM_ALM_D3);
		run_pulses(2'h0, 16'h0001, 16'h0064, `SACM_ALM_D3);
		$display("event alarms done");
	endtask : test_events
	task automatic test_param_change;
		for (int i = 0; i < 2; i++)
		begin
			power_on(6'h00, `SACM_ALM_NONE);
			{param_hw_match, param_in_range} = i ? 2'h1 : 2'h2;
			strobe(param_changed);
			tick(2);
			check(alarm_code, i ? `SACM_ALM_E6 : `SACM_ALM_E5);
		end
		$display("parameter change done");
	endtask : test_param_change
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// main sequence
	initial
	begin
		test_power_on();
		test_events();
		test_param_change();
		report_and_stop();
	end
endmodule : test_servo_alarm_code_monitor
